/* File: logic/spsc_ctrl.sv */
// Stop-grant, snoop sub-state and performance-state controller
`timescale 1ns/1ps

module spsc_ctrl
  import spsc_pkg::*;
#(
  parameter int DIES = SPSC_DIE_COUNT,
  parameter int VW = SPSC_VCODE_W,
  parameter int RW = SPSC_RATIO_W
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Stop-clock request and acknowledge cycles
  input wire logic stop_clock_request_n,
  output logic ack_cycle_req,
  input wire logic ack_cycle_done,
  input wire logic ack_response,
  output logic in_stop_grant,
  output logic grant_late,
  // Halt control from the cores
  input wire logic halt_entry,
  input wire logic deep_halt_enable,
  input wire logic halt_exit,
  // Bus snoop and interrupt transactions
  input wire logic snoop_start,
  input wire logic snoop_serviced,
  input wire logic bus_irq_start,
  input wire logic bus_irq_latched,
  // Event lines; system management, soft init and bus init error active low, local lines high
  input wire logic sys_mgmt_irq_n,
  input wire logic soft_init_n,
  input wire logic bus_init_error_n,
  input wire logic [1:0] local_irq_lines,
  input wire logic core_reset,
  // Pending events and break indication
  output logic [SPSC_EV_W-1:0] pending_events,
  output logic bus_irq_pending,
  input wire logic events_taken,
  input wire logic irq_enable_flag,
  output logic pending_break_n,
  output logic core_init,
  // Performance state request and outputs
  input wire logic [VW-1:0] core0_vcode_req,
  input wire logic [VW-1:0] core1_vcode_req,
  input wire logic [RW-1:0] target_ratio,
  input wire logic pstate_write,
  output logic [VW-1:0] voltage_code,
  output logic [RW-1:0] core_ratio,
  output logic pstate_busy,
  output logic [2:0] power_state
);

  // Current and next power state
  spsc_state_t state;
  spsc_state_t next_state;
  // Remembers whether stop-clock came from halt
  logic from_halt;
  // Acknowledge cycles still to issue
  logic [1:0] acks_left;
  // Grant deadline counter after acknowledge response
  logic [SPSC_GRANT_CNT_W-1:0] grant_cnt;
  logic grant_timing;
  // Previous event line levels for edge detection
  logic [SPSC_EV_W-1:0] ev_prev;
  logic [SPSC_EV_W-1:0] ev_now;
  logic [SPSC_EV_W-1:0] ev_rise;
  // Performance sequencer
  spsc_pstate_t ps;
  logic [VW-1:0] vcode_tgt;
  logic [RW-1:0] ratio_tgt;
  logic req_held;
  logic [RW-1:0] held_ratio;
  logic [VW-1:0] held_vcode;
  logic [VW-1:0] max_vcode;
  logic [RW-1:0] clamp_ratio;
  logic stop_req;
  logic granted;

  assign stop_req = !stop_clock_request_n;
  assign granted = (state == SPSC_GRANT) || (state == SPSC_GRANT_SNOOP);

  // Events in asserted-high form
  assign ev_now = {local_irq_lines[1], local_irq_lines[0],
                   !bus_init_error_n, !soft_init_n, !sys_mgmt_irq_n};
  assign ev_rise = ev_now & ~ev_prev;

  assign max_vcode = (core0_vcode_req > core1_vcode_req) ?
                     core0_vcode_req : core1_vcode_req;
  assign clamp_ratio = (target_ratio > SPSC_RATIO_TOP) ?
                       SPSC_RATIO_TOP : target_ratio;

  // Next power state
  always_comb
  begin
    next_state = state;
    case (state)
      SPSC_NORMAL:
      begin
        if (stop_req)
          next_state = SPSC_ACK;
        else if (halt_entry)
          next_state = deep_halt_enable ? SPSC_DHALT : SPSC_HALT;
      end
      SPSC_ACK:
      begin
        if (acks_left == 2'h0 && !ack_cycle_req)
          next_state = SPSC_GRANT;
      end
      SPSC_GRANT:
      begin
        if (!stop_req)
          next_state = from_halt ? SPSC_HALT : SPSC_NORMAL;
        else if (snoop_start || bus_irq_start)
          next_state = SPSC_GRANT_SNOOP;
      end
      SPSC_GRANT_SNOOP:
      begin
        // Wait for service; back to grant
        if (snoop_serviced || bus_irq_latched)
          next_state = SPSC_GRANT;
      end
      SPSC_HALT:
      begin
        if (stop_req)
          next_state = SPSC_ACK;
        else if (halt_exit || (|pending_events))
          next_state = SPSC_NORMAL;
        else if (snoop_start || bus_irq_start)
          next_state = SPSC_HALT_SNOOP;
      end
      SPSC_HALT_SNOOP:
      begin
        if (snoop_serviced || bus_irq_latched)
          next_state = SPSC_HALT;
      end
      SPSC_DHALT:
      begin
        if (stop_req)
          next_state = SPSC_ACK;
        else if (halt_exit || (|pending_events))
          next_state = SPSC_NORMAL;
        else if (snoop_start || bus_irq_start)
          next_state = SPSC_DHALT_SNOOP;
      end
      SPSC_DHALT_SNOOP:
      begin
        if (snoop_serviced || bus_irq_latched)
          next_state = SPSC_DHALT;
      end
      default:
        next_state = SPSC_NORMAL;
    endcase
  end

  // State register; core reset does not disturb it, so a granted part
  // stays granted while it initializes
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state <= SPSC_NORMAL;
    else if (clk_en)
      state <= next_state;
  end

  // Halt origin of the stop-clock request
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      from_halt <= 1'b0;
    else if (clk_en)
    begin
      if (next_state == SPSC_ACK && state != SPSC_ACK)
        from_halt <= (state == SPSC_HALT) || (state == SPSC_DHALT);
    end
  end

  // Acknowledge cycle issue, one request per die
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acks_left <= 2'h0;
      ack_cycle_req <= 1'b0;
    end
    else if (clk_en)
    begin
      if (next_state == SPSC_ACK && state != SPSC_ACK)
      begin
        acks_left <= 2'(DIES - 1);
        ack_cycle_req <= 1'b1;
      end
      else if (ack_cycle_req && ack_cycle_done)
      begin
        // Next die or finished
        if (acks_left != 2'h0)
          acks_left <= acks_left - 2'h1;
        else
          ack_cycle_req <= 1'b0;
      end
    end
  end

  // Deadline watch from acknowledge response to grant
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      grant_cnt <= '0;
      grant_timing <= 1'b0;
      grant_late <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state == SPSC_ACK && ack_response)
      begin
        grant_timing <= 1'b1;
        grant_cnt <= '0;
      end
      else if (grant_timing)
      begin
        if (state != SPSC_ACK)
          grant_timing <= 1'b0;
        else if (grant_cnt == SPSC_GRANT_CNT_W'(SPSC_GRANT_LIMIT_CLKS))
          grant_late <= 1'b1;
        else
          grant_cnt <= grant_cnt + 1'b1;
      end
    end
  end

  // Status outputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      in_stop_grant <= 1'b0;
      power_state <= 3'h0;
    end
    else if (clk_en)
    begin
      in_stop_grant <= (next_state == SPSC_GRANT) ||
                       (next_state == SPSC_GRANT_SNOOP);
      power_state <= next_state;
    end
  end

  // Event line history
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ev_prev <= '0;
    else if (clk_en)
      ev_prev <= ev_now;
  end

  // Pending event flags; a new event beats the clear in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pending_events <= '0;
    else if (clk_en)
    begin
      // Latch in stop-grant; bus error; one flag each
      if (granted)
        pending_events <= pending_events | ev_rise;
      else if (state == SPSC_NORMAL && events_taken)
        pending_events <= ev_rise;
      else
        pending_events <= pending_events | ev_rise;
    end
  end

  // Interrupts delivered as bus transactions
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bus_irq_pending <= 1'b0;
    else if (clk_en)
    begin
      if (bus_irq_latched)
        bus_irq_pending <= 1'b1;
      else if (state == SPSC_NORMAL && events_taken)
        bus_irq_pending <= 1'b0;
    end
  end

  // Pending-break, regardless of the interrupt enable flag
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pending_break_n <= 1'b1;
    else if (clk_en)
    begin
      // Any pending interrupt, masked or not
      pending_break_n <= !(granted &&
        ((|pending_events) || bus_irq_pending ||
         (bus_irq_latched && (irq_enable_flag || !irq_enable_flag))));
    end
  end

  // Core initialization pulse on reset
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      core_init <= 1'b0;
    else if (clk_en)
      core_init <= core_reset;
  end

  // Deep halt and its snoop state hold off new operating-point transitions
  function automatic logic frozen_state();
    return (state == SPSC_DHALT_SNOOP) || (state == SPSC_DHALT);
  endfunction

  // Held software request while a transition runs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_held <= 1'b0;
      held_ratio <= SPSC_RATIO_RESET;
      held_vcode <= SPSC_VCODE_RESET;
    end
    else if (clk_en)
    begin
      if (pstate_write && (ps != SPSC_PS_IDLE || req_held))
      begin
        req_held <= 1'b1;
        held_ratio <= clamp_ratio;
        held_vcode <= max_vcode;
      end
      else if (ps == SPSC_PS_IDLE && !frozen_state())
        req_held <= 1'b0;
    end
  end

  // Performance sequencer; only core ratio moves, bus clock never
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ps <= SPSC_PS_IDLE;
      vcode_tgt <= SPSC_VCODE_RESET;
      ratio_tgt <= SPSC_RATIO_RESET;
      voltage_code <= SPSC_VCODE_RESET;
      core_ratio <= SPSC_RATIO_RESET;
      pstate_busy <= 1'b0;
    end
    else if (clk_en)
    begin
      case (ps)
        SPSC_PS_IDLE:
        begin
          if (!frozen_state() && (pstate_write || req_held))
          begin
            vcode_tgt <= req_held ? held_vcode : max_vcode;
            ratio_tgt <= req_held ? held_ratio : clamp_ratio;
            pstate_busy <= 1'b1;
            // Any rise of code first; down: ratio first
            if (((req_held ? held_ratio : clamp_ratio) > core_ratio) ||
                ((req_held ? held_vcode : max_vcode) > voltage_code))
              ps <= SPSC_PS_VUP;
            else
              ps <= SPSC_PS_RATIO;
          end
        end
        SPSC_PS_VUP:
        begin
          if (voltage_code < vcode_tgt)
            voltage_code <= voltage_code + SPSC_VCODE_STEP;
          else
            ps <= SPSC_PS_RATIO;
        end
        SPSC_PS_RATIO:
        begin
          core_ratio <= ratio_tgt;
          ps <= (voltage_code > vcode_tgt) ? SPSC_PS_VDOWN : SPSC_PS_IDLE;
          // Stay busy while a held request waits, so no idle gap shows
          pstate_busy <= (voltage_code > vcode_tgt) || req_held ||
                         pstate_write;
        end
        SPSC_PS_VDOWN:
        begin
          if (voltage_code > vcode_tgt)
            voltage_code <= voltage_code - SPSC_VCODE_STEP;
          else
          begin
            ps <= SPSC_PS_IDLE;
            // Busy continues into a held request
            pstate_busy <= req_held || pstate_write;
          end
        end
        default:
          ps <= SPSC_PS_IDLE;
      endcase
    end
  end

endmodule

/* File: logic/spsc_pkg.sv */
// Package of constants and types for the stop-grant power state controller
package spsc_pkg;

  // Stop-grant acknowledge cycles, one per die
  localparam int SPSC_DIE_COUNT = 2;
  // Bus clocks allowed from acknowledge response to stop-grant
  localparam int SPSC_GRANT_LIMIT_CLKS = 20;
  // Width of the grant deadline counter
  localparam int SPSC_GRANT_CNT_W = 5;
  // Voltage code and ratio field widths
  localparam int SPSC_VCODE_W = 6;
  localparam int SPSC_RATIO_W = 5;
  // One voltage-code step is 12.5 mV, expressed in tenths of a millivolt
  localparam int SPSC_VSTEP_UV10 = 125;
  // Code change per step
  localparam logic [5:0] SPSC_VCODE_STEP = 6'h01;
  // Voltage code and ratio after reset
  localparam logic [5:0] SPSC_VCODE_RESET = 6'h20;
  localparam logic [4:0] SPSC_RATIO_RESET = 5'h08;
  // Top ratio that must never be exceeded
  localparam logic [4:0] SPSC_RATIO_TOP = 5'h10;
  // Latched event positions: system management, soft init, bus init, local 0/1
  localparam int SPSC_EV_SMI = 0;
  localparam int SPSC_EV_INIT = 1;
  localparam int SPSC_EV_BUS_INIT_ERROR_N = 2;
  localparam int SPSC_EV_LINT0 = 3;
  localparam int SPSC_EV_LINT1 = 4;
  localparam int SPSC_EV_W = 5;

  // Power state machine
  typedef enum logic [2:0] {
    SPSC_NORMAL = 3'b000,
    SPSC_ACK = 3'b001,
    SPSC_GRANT = 3'b010,
    SPSC_GRANT_SNOOP = 3'b011,
    SPSC_HALT = 3'b100,
    SPSC_HALT_SNOOP = 3'b101,
    SPSC_DHALT = 3'b110,
    SPSC_DHALT_SNOOP = 3'b111
  } spsc_state_t;

  // Performance transition sequencer
  typedef enum logic [1:0] {
    SPSC_PS_IDLE = 2'b00,
    SPSC_PS_VUP = 2'b01,
    SPSC_PS_RATIO = 2'b10,
    SPSC_PS_VDOWN = 2'b11
  } spsc_pstate_t;

endpackage

/* File: verification/spsc_ctrl_sva.sv */
// Checker of stop-grant, snoop and voltage ordering at the ports
`timescale 1ns/1ps
module spsc_ctrl_chk
  import spsc_pkg::*;
#(
  parameter int VW = SPSC_VCODE_W,
  parameter int RW = SPSC_RATIO_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Stop-clock handshake
  input wire logic stop_clock_request_n,
  input wire logic ack_cycle_req,
  input wire logic ack_cycle_done,
  input wire logic ack_response,
  input wire logic in_stop_grant,
  // Snoops and events
  input wire logic snoop_serviced,
  input wire logic bus_irq_latched,
  input wire logic snoop_start,
  input wire logic core_reset,
  input wire logic core_init,
  input wire logic [SPSC_EV_W-1:0] pending_events,
  input wire logic pending_break_n,
  // Operating point
  input wire logic [VW-1:0] voltage_code,
  input wire logic [RW-1:0] core_ratio,
  input wire logic [2:0] power_state
);
  // Acknowledge cycles run while the request is up
  logic [1:0] dones;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      dones <= 2'h0;
    else if (!ack_cycle_req)
      dones <= 2'h0;
    else if (ack_cycle_done)
      dones <= dones + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ack_start: assert property ($fell(stop_clock_request_n) &&
    power_state == SPSC_NORMAL |=> ack_cycle_req) else $error("no ack");
  a_two_acks: assert property ($fell(ack_cycle_req) |-> dones == 2'h2)
    else $error("ack count");
  a_grant_limit: assert property (ack_response |-> ##[0:20] in_stop_grant)
    else $error("grant late");
  a_grant_exit: assert property (power_state == SPSC_GRANT &&
    stop_clock_request_n |=> power_state inside {SPSC_NORMAL, SPSC_HALT})
    else $error("no exit");
  a_snoop_enter: assert property (power_state == SPSC_GRANT &&
    snoop_start |=> power_state == SPSC_GRANT_SNOOP) else $error("snoop");
  a_snoop_hold: assert property (power_state == SPSC_GRANT_SNOOP &&
    !snoop_serviced && !bus_irq_latched && !stop_clock_request_n
    |=> power_state == SPSC_GRANT_SNOOP) else $error("snoop left");
  a_snoop_return: assert property (power_state[0] &&
    power_state != SPSC_ACK && snoop_serviced
    |=> power_state == {$past(power_state[2:1]), 1'b0})
    else $error("bad return");
  a_break_set: assert property ((power_state == SPSC_GRANT &&
    |pending_events)[*2] |-> !pending_break_n) else $error("no break");
  a_break_idle: assert property ((!in_stop_grant)[*2] |->
    pending_break_n) else $error("stray break");
  a_vcode_step: assert property (!$stable(voltage_code) |->
    voltage_code == $past(voltage_code) + SPSC_VCODE_STEP ||
    voltage_code == $past(voltage_code) - SPSC_VCODE_STEP)
    else $error("vcode jump");
  a_up_order: assert property (core_ratio > $past(core_ratio) |->
    $stable(voltage_code) && core_ratio <= SPSC_RATIO_TOP)
    else $error("up order");
  a_down_order: assert property (voltage_code < $past(voltage_code)
    |-> $stable(core_ratio)) else $error("down order");
  a_dhalt_keep: assert property (power_state == SPSC_DHALT_SNOOP |=>
    $stable(voltage_code) && $stable(core_ratio)) else $error("point");
  a_reset_stays: assert property (power_state == SPSC_GRANT &&
    core_reset && !stop_clock_request_n |=> in_stop_grant && core_init)
    else $error("reset left grant");
  c_grant_snoop: cover property (power_state == SPSC_GRANT_SNOOP);
  c_dhalt_snoop: cover property (power_state == SPSC_DHALT_SNOOP);
  c_break: cover property (!pending_break_n);
endmodule
bind spsc_ctrl spsc_ctrl_chk #(.VW(VW), .RW(RW)) i_chk (.clk(clk),
  .resetn(resetn), .stop_clock_request_n(stop_clock_request_n),
  .ack_cycle_req(ack_cycle_req), .ack_cycle_done(ack_cycle_done),
  .ack_response(ack_response), .in_stop_grant(in_stop_grant),
  .snoop_serviced(snoop_serviced), .bus_irq_latched(bus_irq_latched),
  .snoop_start(snoop_start), .core_reset(core_reset),
  .core_init(core_init), .pending_events(pending_events),
  .pending_break_n(pending_break_n), .voltage_code(voltage_code),
  .core_ratio(core_ratio), .power_state(power_state));

/* File: verification/spsc_fsb_model.sv */
// Chipset model that runs the acknowledge cycles asked for
`timescale 1ns/1ps
module spsc_fsb_model
#(
  parameter int GAP = 1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Acknowledge handshake
  input wire logic ack_cycle_req,
  output logic ack_cycle_done,
  output logic ack_response
);
  // Idle cycles counted before each cycle; GAP sets slowness
  int wait_cnt;
  // One cycle per request, response phase the clock after
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_cnt <= 0;
      ack_cycle_done <= 1'b0;
      ack_response <= 1'b0;
    end
    else
    begin
      ack_response <= #1 ack_cycle_done;
      ack_cycle_done <= #1 ack_cycle_req && !ack_cycle_done &&
        wait_cnt >= GAP;
      wait_cnt <= (ack_cycle_req && !ack_cycle_done) ? wait_cnt + 1 : 0;
    end
  end
endmodule

/* File: verification/testbench.sv */
// Testbench for the stop-grant power state controller
`timescale 1ns/1ps
module testbench
  import spsc_pkg::*;
;
  logic clk, resetn, clk_en, stop_clock_request_n, ack_cycle_req;
  logic ack_cycle_done, ack_response, in_stop_grant, grant_late;
  logic halt_entry, deep_halt_enable, halt_exit, snoop_start;
  logic snoop_serviced, bus_irq_start, bus_irq_latched, sys_mgmt_irq_n;
  logic soft_init_n, bus_init_error_n, core_reset, bus_irq_pending;
  logic events_taken, irq_enable_flag, pending_break_n, core_init;
  logic pstate_write, pstate_busy;
  logic [1:0] local_irq_lines;
  logic [4:0] pending_events, target_ratio, core_ratio;
  logic [5:0] core0_vcode_req, core1_vcode_req, voltage_code;
  logic [2:0] power_state;
  int err_count, checks, acks, cyc;
  spsc_ctrl i_spsc_ctrl (.clk(clk), .resetn(resetn), .clk_en(clk_en),
    .stop_clock_request_n(stop_clock_request_n),
    .ack_cycle_req(ack_cycle_req), .ack_cycle_done(ack_cycle_done),
    .ack_response(ack_response), .in_stop_grant(in_stop_grant),
    .grant_late(grant_late), .halt_entry(halt_entry),
    .deep_halt_enable(deep_halt_enable), .halt_exit(halt_exit),
    .snoop_start(snoop_start), .snoop_serviced(snoop_serviced),
    .bus_irq_start(bus_irq_start), .bus_irq_latched(bus_irq_latched),
    .sys_mgmt_irq_n(sys_mgmt_irq_n), .soft_init_n(soft_init_n),
    .bus_init_error_n(bus_init_error_n),
    .local_irq_lines(local_irq_lines), .core_reset(core_reset),
    .pending_events(pending_events), .bus_irq_pending(bus_irq_pending),
    .events_taken(events_taken), .irq_enable_flag(irq_enable_flag),
    .pending_break_n(pending_break_n), .core_init(core_init),
    .core0_vcode_req(core0_vcode_req), .core1_vcode_req(core1_vcode_req),
    .target_ratio(target_ratio), .pstate_write(pstate_write),
    .voltage_code(voltage_code), .core_ratio(core_ratio),
    .pstate_busy(pstate_busy), .power_state(power_state));
  spsc_fsb_model #(.GAP(3)) i_spsc_fsb_model (.clk(clk), .resetn(resetn),
    .ack_cycle_req(ack_cycle_req), .ack_cycle_done(ack_cycle_done),
    .ack_response(ack_response));
  // Clock and cycle limit; a hang counts as a mismatch
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (ack_cycle_done)
      acks++;
    if (cyc == 5000)
    begin
      err_count++;
      end_sim();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-clock pulse of either polarity, then a settling clock
  task automatic pulse(ref logic s);
    s = ~s;
    tick(1);
    s = ~s;
    tick(1);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ps(input logic [2:0] s);
    int i;
    i = 0;
    while (power_state !== s && i < 60)
    begin
      tick(1);
      i++;
    end
    check(power_state, s);
  endtask
  task automatic wait_idle();
    int i;
    i = 0;
    while (pstate_busy !== 1'b0 && i < 100)
    begin
      tick(1);
      i++;
    end
    check(pstate_busy, 1'b0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic set_ps(input logic [5:0] v0, input logic [5:0] v1,
    input logic [4:0] r);
    core0_vcode_req = v0;
    core1_vcode_req = v1;
    target_ratio = r;
    pulse(pstate_write);
  endtask
  initial
  begin
    {clk_en, stop_clock_request_n, sys_mgmt_irq_n, soft_init_n} = 4'hF;
    resetn = 1'b0;
    cyc = 0;
    err_count = 0;
    checks = 0;
    acks = 0;
    bus_init_error_n = 1'b1;
    {halt_entry, deep_halt_enable, halt_exit, snoop_start} = 4'h0;
    {snoop_serviced, bus_irq_start, bus_irq_latched, core_reset} = 4'h0;
    {events_taken, irq_enable_flag, pstate_write} = 3'h0;
    local_irq_lines = 2'h0;
    core0_vcode_req = SPSC_VCODE_RESET;
    core1_vcode_req = SPSC_VCODE_RESET;
    target_ratio = SPSC_RATIO_RESET;
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    tick(2);
    // request held until granted; other inputs left idle
    stop_clock_request_n = 1'b0;
    wait_ps(SPSC_GRANT);
    check(acks, 8'h02);
    check({grant_late, in_stop_grant}, 8'h01);
    core_reset = 1'b1;
    tick(2);
    check({core_init, power_state}, {4'h1, SPSC_GRANT});
    core_reset = 1'b0;
    pulse(sys_mgmt_irq_n);
    pulse(sys_mgmt_irq_n);
    pulse(soft_init_n);
    pulse(bus_init_error_n);
    local_irq_lines = 2'h3;
    tick(1);
    local_irq_lines = 2'h0;
    tick(2);
    check(pending_events, 8'h1F);
    check(pending_break_n, 1'b0);
    check(power_state, SPSC_GRANT);
    pulse(snoop_start);
    tick(3);
    check(power_state, SPSC_GRANT_SNOOP);
    pulse(snoop_serviced);
    check(power_state, SPSC_GRANT);
    pulse(bus_irq_start);
    pulse(bus_irq_latched);
    check({bus_irq_pending, power_state}, {4'h1, SPSC_GRANT});
    stop_clock_request_n = 1'b1;
    wait_ps(SPSC_NORMAL);
    // Break output is registered from the state, so it clears a clock later
    tick(1);
    check({pending_break_n, pending_events}, 8'h3F);
    pulse(events_taken);
    check({bus_irq_pending, pending_events}, 8'h00);
    $display("test stop_grant done");
    set_ps(6'h25, 6'h22, 5'h0C);
    // Clock enable low freezes the stepping after its first code step
    clk_en = 1'b0;
    tick(3);
    check({pstate_busy, voltage_code},
      {1'b1, SPSC_VCODE_RESET + SPSC_VCODE_STEP});
    clk_en = 1'b1;
    wait_idle();
    check({voltage_code, 2'h0}, {6'h25, 2'h0});
    check(core_ratio, 8'h0C);
    set_ps(6'h1E, 6'h21, 5'h0A);
    wait_idle();
    check({core_ratio, voltage_code[2:0]}, {5'h0A, 3'h1});
    set_ps(6'h23, 6'h20, 5'h1F);
    wait_idle();
    check(core_ratio, SPSC_RATIO_TOP);
    set_ps(6'h24, 6'h20, 5'h0C);
    set_ps(6'h22, 6'h20, 5'h09);
    wait_idle();
    check({core_ratio, voltage_code[2:0]}, {5'h09, 3'h2});
    $display("test pstate done");
    pulse(halt_entry);
    check(power_state, SPSC_HALT);
    pulse(snoop_start);
    check(power_state, SPSC_HALT_SNOOP);
    pulse(snoop_serviced);
    check(power_state, SPSC_HALT);
    stop_clock_request_n = 1'b0;
    wait_ps(SPSC_GRANT);
    stop_clock_request_n = 1'b1;
    wait_ps(SPSC_HALT);
    pulse(halt_exit);
    wait_ps(SPSC_NORMAL);
    deep_halt_enable = 1'b1;
    pulse(halt_entry);
    wait_ps(SPSC_DHALT);
    wait_idle();
    pulse(snoop_start);
    check(power_state, SPSC_DHALT_SNOOP);
    pulse(snoop_serviced);
    check(power_state, SPSC_DHALT);
    pulse(halt_exit);
    wait_ps(SPSC_NORMAL);
    $display("test halt done");
    end_sim();
  end
endmodule
